// ===== verilog/ccdet_consts.svh
// constants of the ccd edge timing and front-end control block
// assumes inclusion by bare name from the package and the top module
`ifndef CCDET_CONSTS_SVH
`define CCDET_CONSTS_SVH

// register offsets
`define CCDET_ADDR_OPER      8'h00
`define CCDET_ADDR_OUTC      8'h04
`define CCDET_ADDR_HEDGE     8'h60
`define CCDET_ADDR_RGEDGE    8'h61
`define CCDET_ADDR_DRV       8'h62
`define CCDET_ADDR_SAMP      8'h63
`define CCDET_ADDR_DPHASE    8'h64

// reset values
`define CCDET_RST_OPER       12'h004
`define CCDET_RST_OUTC       6'h04
`define CCDET_RST_HEDGE      13'h1001
`define CCDET_RST_RGEDGE     13'h0801
`define CCDET_RST_DRV        15'h0000
`define CCDET_RST_SAMP       12'h024
`define CCDET_RST_DPHASE     6'h00

// field widths and positions
`define CCDET_OPER_W         12
`define CCDET_OUTC_W         6
`define CCDET_EDGE_REG_W     13
`define CCDET_DRV_W          15
`define CCDET_SAMP_W         12
`define CCDET_DPHASE_W       6
`define CCDET_OUTC_TRI_BIT   3

// timing core
`define CCDET_PHASES         48
`define CCDET_QUAD_SPAN      12
`define CCDET_LAST_PHASE     6'h2F
`define CCDET_OFFSET_LIMIT   4'hC

`endif

// ===== verilog/ccdet_pkg.sv
// types and helper functions of the ccd edge timing block
// assumes ccdet_consts.svh is on the include path
`include "ccdet_consts.svh"

package ccdet_pkg;

    typedef logic [5:0] ccdet_edge_t;

    typedef struct packed {
        ccdet_edge_t fall;
        ccdet_edge_t rise;
        logic        pol;
    } ccdet_clk_edges_t;

    typedef struct packed {
        logic [2:0] rg;
        logic [2:0] h4;
        logic [2:0] h3;
        logic [2:0] h2;
        logic [2:0] h1;
    } ccdet_drive_t;

    typedef struct packed {
        ccdet_edge_t level_pos;
        ccdet_edge_t ref_pos;
    } ccdet_samp_t;

    typedef struct packed {
        logic [1:0] gain;
        logic       test_hi;
        logic       dc_bypass;
        logic [1:0] test_lo;
        logic       blank_lvl;
        logic       quick;
        logic       fast;
        logic       clamp_on;
        logic [1:0] pwr;
    } ccdet_oper_t;

    typedef struct packed {
        logic       gray;
        logic       latch_transp;
        logic       tristate;
        logic [2:0] steer_cfg;
    } ccdet_outc_t;

    typedef enum logic [2:0] {
        CCDET_PWR_NORMAL  = 3'b001,
        CCDET_PWR_STANDBY = 3'b010,
        CCDET_PWR_DOWN    = 3'b100
    } ccdet_pwr_t;

    typedef enum logic [2:0] {
        CCDET_GAIN_0DB  = 3'b001,
        CCDET_GAIN_M2DB = 3'b010,
        CCDET_GAIN_M4DB = 3'b100
    } ccdet_gain_t;

    // {valid, position}: quadrant*12 + offset, offsets above 11 invalid
    function automatic logic [6:0] ccdet_edge_pos(input ccdet_edge_t f);
        logic [5:0] pos;
        logic       ok;
        pos = 6'({f[5:4], 3'b000}) + 6'({f[5:4], 2'b00}) + 6'({2'b00, f[3:0]});
        ok  = (f[3:0] < `CCDET_OFFSET_LIMIT);
        return {ok, pos};
    endfunction

    function automatic logic [9:0] ccdet_gray(input logic [9:0] b);
        return b ^ (b >> 1);
    endfunction

endpackage

// ===== verilog/ccdet_edge_gen.sv
// one programmable pixel-rate clock built from rise and fall positions
// assumes phase steps 0..47 once per ref_clk cycle
`timescale 1ns/100ps

module ccdet_edge_gen (
    input  wire logic                       ref_clk,
    input  wire logic                       resetn,
    input  wire ccdet_pkg::ccdet_edge_t     phase,
    input  wire ccdet_pkg::ccdet_clk_edges_t edges,
    output logic                            clk_out
);
    import ccdet_pkg::*;

    logic [6:0] rise_dec;
    logic [6:0] fall_dec;
    logic       rise_hit;
    logic       fall_hit;
    logic       level_r;
    logic       level_nxt;

    assign rise_dec  = ccdet_edge_pos(edges.rise);
    assign fall_dec  = ccdet_edge_pos(edges.fall);
    // an invalid offset never matches, so that edge simply does not occur
    assign rise_hit  = rise_dec[6] && (phase == rise_dec[5:0]);
    assign fall_hit  = fall_dec[6] && (phase == fall_dec[5:0]);
    // rise wins when both sit on the same position
    assign level_nxt = rise_hit ? 1'b1 : (fall_hit ? 1'b0 : level_r);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            level_r <= 1'b0;
        end else begin
            level_r <= level_nxt;
        end
    end

    // polarity 1 passes the pulse, 0 inverts it
    assign clk_out = edges.pol ? level_r : ~level_r;

    sequence s_rise_hit;
        rise_hit;
    endsequence

    sequence s_fall_only;
        fall_hit && !rise_hit;
    endsequence

    a_rise_sets_level: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_rise_hit |=> level_r)
        else $error("edge gen: level not high after rise position");

    a_fall_clears_lvl: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_fall_only |=> !level_r)
        else $error("edge gen: level not low after fall position");

endmodule

// ===== verilog/ccdet_top.sv
// timing core and front-end control registers of the ccd processor
// assumes ref_clk is the 48x fine-step clock; master_clock_in is sampled on it
`timescale 1ns/100ps
`include "ccdet_consts.svh"

module ccdet_top (
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    input  wire logic                   master_clock_in,
    input  wire logic                   reg_wr_en,
    input  wire logic                   reg_rd_en,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [15:0]            reg_wdata,
    output logic      [15:0]            reg_rd_data,
    output logic                        reg_rd_valid,
    output ccdet_pkg::ccdet_edge_t      pixel_phase,
    output logic                        horiz_clock_1,
    output logic                        horiz_clock_2,
    output logic                        horiz_clock_3,
    output logic                        horiz_clock_4,
    output logic                        reset_gate_clock,
    output logic                        horiz_clock_1_oe,
    output logic                        horiz_clock_2_oe,
    output logic                        horiz_clock_3_oe,
    output logic                        horiz_clock_4_oe,
    output logic                        reset_gate_oe,
    output ccdet_pkg::ccdet_drive_t     drive_strength,
    output logic                        reference_sample_strobe,
    output logic                        level_sample_strobe,
    input  wire logic                   pixel_blank_pulse_n,
    input  wire logic [9:0]             adc_code,
    input  wire logic [9:0]             clamp_level,
    input  wire logic                   gain_update,
    output logic      [9:0]             data_out,
    output logic                        data_out_oe,
    output ccdet_pkg::ccdet_pwr_t       power_state,
    output logic                        black_clamp_on,
    output logic                        black_clamp_fast,
    output logic                        quick_clamp_pulse,
    output logic                        dc_restore_bypass,
    output ccdet_pkg::ccdet_gain_t      sampler_gain
);
    import ccdet_pkg::*;

    // register file
    ccdet_oper_t      oper_r;
    ccdet_outc_t      outc_r;
    ccdet_clk_edges_t hedge_r;
    ccdet_clk_edges_t rgedge_r;
    ccdet_drive_t     drv_r;
    ccdet_samp_t      samp_r;
    ccdet_edge_t      dphase_r;

    logic        hit_oper;
    logic        hit_outc;
    logic        hit_hedge;
    logic        hit_rgedge;
    logic        hit_drv;
    logic        hit_samp;
    logic        hit_dphase;
    logic [15:0] rd_mux;
    logic [15:0] rd_data_r;
    logic        rd_valid_r;

    // timing core
    logic        mclk_d_r;
    logic        mclk_rise;
    ccdet_edge_t phase_r;
    ccdet_edge_t phase_nxt;

    logic        h1_lvl;
    logic        h3_lvl;
    logic        rg_lvl;

    logic [6:0]  ref_dec;
    logic [6:0]  lvl_dec;
    logic [6:0]  dph_dec;
    logic        ref_hit;
    logic        lvl_hit;
    logic        launch;
    logic        ref_strobe_r;
    logic        lvl_strobe_r;

    // data path
    logic        blanking;
    logic [9:0]  sel_code;
    logic [9:0]  out_code;
    logic        data_load;
    logic [9:0]  data_out_r;
    logic        quick_r;

    assign hit_oper   = (reg_addr == `CCDET_ADDR_OPER);
    assign hit_outc   = (reg_addr == `CCDET_ADDR_OUTC);
    assign hit_hedge  = (reg_addr == `CCDET_ADDR_HEDGE);
    assign hit_rgedge = (reg_addr == `CCDET_ADDR_RGEDGE);
    assign hit_drv    = (reg_addr == `CCDET_ADDR_DRV);
    assign hit_samp   = (reg_addr == `CCDET_ADDR_SAMP);
    assign hit_dphase = (reg_addr == `CCDET_ADDR_DPHASE);

    // test bits are stored as written; keeping them zero is software's job
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            oper_r   <= `CCDET_RST_OPER;
            outc_r   <= `CCDET_RST_OUTC;
            hedge_r  <= `CCDET_RST_HEDGE;
            rgedge_r <= `CCDET_RST_RGEDGE;
            drv_r    <= `CCDET_RST_DRV;
            samp_r   <= `CCDET_RST_SAMP;
            dphase_r <= `CCDET_RST_DPHASE;
        end else if (reg_wr_en) begin
            if (hit_oper) begin
                oper_r <= reg_wdata[`CCDET_OPER_W-1:0];
            end else if (hit_outc) begin
                outc_r <= reg_wdata[`CCDET_OUTC_W-1:0];
            end else if (hit_hedge) begin
                hedge_r <= reg_wdata[`CCDET_EDGE_REG_W-1:0];
            end else if (hit_rgedge) begin
                rgedge_r <= reg_wdata[`CCDET_EDGE_REG_W-1:0];
            end else if (hit_drv) begin
                drv_r <= reg_wdata[`CCDET_DRV_W-1:0];
            end else if (hit_samp) begin
                samp_r <= reg_wdata[`CCDET_SAMP_W-1:0];
            end else if (hit_dphase) begin
                dphase_r <= reg_wdata[`CCDET_DPHASE_W-1:0];
            end
        end
    end

    // unmapped addresses read as zero
    always_comb begin
        rd_mux = 16'h0000;
        if (hit_oper) begin
            rd_mux = 16'(oper_r);
        end else if (hit_outc) begin
            rd_mux = 16'(outc_r);
        end else if (hit_hedge) begin
            rd_mux = 16'(hedge_r);
        end else if (hit_rgedge) begin
            rd_mux = 16'(rgedge_r);
        end else if (hit_drv) begin
            rd_mux = 16'(drv_r);
        end else if (hit_samp) begin
            rd_mux = 16'(samp_r);
        end else if (hit_dphase) begin
            rd_mux = 16'(dphase_r);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rd_data_r  <= 16'h0000;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= reg_rd_en;
            if (reg_rd_en) begin
                rd_data_r <= rd_mux;
            end
        end
    end

    assign reg_rd_data  = rd_data_r;
    assign reg_rd_valid = rd_valid_r;

    // each rising master clock restarts the 48-step count, so a pixel
    // clock slower than 48 ref cycles wraps from the last step back to zero
    assign mclk_rise = master_clock_in && !mclk_d_r;
    assign phase_nxt = mclk_rise ? 6'h00 :
                       (phase_r == `CCDET_LAST_PHASE) ? 6'h00 : 6'(phase_r + 6'h01);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            mclk_d_r <= 1'b0;
            phase_r  <= 6'h00;
        end else begin
            mclk_d_r <= master_clock_in;
            phase_r  <= phase_nxt;
        end
    end

    assign pixel_phase = phase_r;

    ccdet_edge_gen u_h1_gen (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .phase   (phase_r),
        .edges   (hedge_r),
        .clk_out (h1_lvl)
    );

    ccdet_edge_gen u_rg_gen (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .phase   (phase_r),
        .edges   (rgedge_r),
        .clk_out (rg_lvl)
    );

    // h3 shares the horizontal edge register with h1
    assign h3_lvl           = h1_lvl;
    assign horiz_clock_1    = h1_lvl;
    assign horiz_clock_3    = h3_lvl;
    assign horiz_clock_2    = ~h1_lvl;
    assign horiz_clock_4    = ~h3_lvl;
    assign reset_gate_clock = rg_lvl;

    assign horiz_clock_1_oe = |drv_r.h1;
    assign horiz_clock_2_oe = |drv_r.h2;
    assign horiz_clock_3_oe = |drv_r.h3;
    assign horiz_clock_4_oe = |drv_r.h4;
    assign reset_gate_oe    = |drv_r.rg;
    assign drive_strength   = drv_r;

    assign ref_dec = ccdet_edge_pos(samp_r.ref_pos);
    assign lvl_dec = ccdet_edge_pos(samp_r.level_pos);
    assign dph_dec = ccdet_edge_pos(dphase_r);
    assign ref_hit = ref_dec[6] && (phase_r == ref_dec[5:0]);
    assign lvl_hit = lvl_dec[6] && (phase_r == lvl_dec[5:0]);
    assign launch  = dph_dec[6] && (phase_r == dph_dec[5:0]);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ref_strobe_r <= 1'b0;
            lvl_strobe_r <= 1'b0;
        end else begin
            ref_strobe_r <= ref_hit;
            lvl_strobe_r <= lvl_hit;
        end
    end

    assign reference_sample_strobe = ref_strobe_r;
    assign level_sample_strobe     = lvl_strobe_r;

    // output code: blanking substitution, then optional gray coding
    assign blanking  = !pixel_blank_pulse_n;
    assign sel_code  = !blanking ? adc_code :
                       (oper_r.blank_lvl ? clamp_level : 10'h000);
    assign out_code  = outc_r.gray ? ccdet_gray(sel_code) : sel_code;
    // transparent mode follows the input every step, costing phase control
    assign data_load = outc_r.latch_transp || launch;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            data_out_r <= 10'h000;
            quick_r    <= 1'b0;
        end else begin
            quick_r <= gain_update && oper_r.quick;
            if (data_load) begin
                data_out_r <= out_code;
            end
        end
    end

    assign data_out          = data_out_r;
    assign data_out_oe       = !outc_r.tristate;
    assign quick_clamp_pulse = quick_r;

    assign power_state = (oper_r.pwr == 2'b00) ? CCDET_PWR_NORMAL :
                         (oper_r.pwr == 2'b01) ? CCDET_PWR_STANDBY : CCDET_PWR_DOWN;
    assign black_clamp_on    = oper_r.clamp_on;
    assign black_clamp_fast  = oper_r.fast;
    assign dc_restore_bypass = oper_r.dc_bypass && blanking;
    assign sampler_gain = (oper_r.gain == 2'b01) ? CCDET_GAIN_M2DB :
                          (oper_r.gain == 2'b10) ? CCDET_GAIN_M4DB : CCDET_GAIN_0DB;

    default clocking cb_main @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_step_on;
        !mclk_rise && (phase_r != `CCDET_LAST_PHASE);
    endsequence

    sequence s_ref_pos;
        ref_hit;
    endsequence

    sequence s_hold_latched;
        !outc_r.latch_transp && !launch;
    endsequence

    a_phase_step: assert property (s_step_on |=> phase_r == 6'($past(phase_r) + 6'h01))
        else $error("phase did not advance by one step");

    a_phase_realign: assert property (mclk_rise or (phase_r == `CCDET_LAST_PHASE)
        |=> phase_r == 6'h00)
        else $error("phase did not restart at zero");

    a_h_inverse: assert property ($rose(horiz_clock_1) |-> $fell(horiz_clock_2))
        else $error("clock 2 not inverse of clock 1");

    a_ref_strobe: assert property (s_ref_pos |=> reference_sample_strobe ##1
        (!reference_sample_strobe || $past(ref_hit)))
        else $error("reference strobe missing at its position");

    a_level_strobe: assert property (!lvl_hit |=> !level_sample_strobe)
        else $error("level strobe outside its position");

    a_data_hold: assert property (s_hold_latched |=> $stable(data_out))
        else $error("data changed away from output phase");

    a_data_launch: assert property (launch && !outc_r.gray |=> data_out == $past(sel_code))
        else $error("data not launched at output phase");

    a_blank_zero: assert property (launch && blanking && !oper_r.blank_lvl
        |=> data_out == 10'h000)
        else $error("blanked output not zero");

    a_gray_code: assert property (outc_r.latch_transp && outc_r.gray
        |=> data_out == ccdet_gray($past(sel_code)))
        else $error("gray coded output wrong");

    a_tristate_wr: assert property (reg_wr_en && hit_outc && reg_wdata[`CCDET_OUTC_TRI_BIT]
        |=> !data_out_oe)
        else $error("data outputs still driven after float request");

    a_drive_off: assert property (reg_wr_en && hit_drv && (reg_wdata[2:0] == 3'h0)
        |=> !horiz_clock_1_oe)
        else $error("clock 1 driven with strength zero");

    a_quick_clamp: assert property (gain_update |=> quick_clamp_pulse == $past(oper_r.quick))
        else $error("quick clamp pulse wrong after gain update");

    a_gain_map: assert property ((oper_r.gain == 2'b11) |-> sampler_gain == CCDET_GAIN_0DB)
        else $error("gain code 11 not 0 dB");

    a_power_map: assert property (oper_r.pwr[1] |-> power_state == CCDET_PWR_DOWN)
        else $error("power field 2 or 3 not power-down");

    a_reset_defaults: assert property (!$past(resetn) |-> black_clamp_on && !black_clamp_fast
        && power_state == CCDET_PWR_NORMAL)
        else $error("wrong clamp or power state after reset");

    a_dc_bypass: assert property (!blanking |-> !dc_restore_bypass)
        else $error("dc restore bypassed outside blanking");

endmodule

// ===== tb/ccdet_ccd_model.sv
// ccd sensor stand-in: pixel master clock and a moving pixel code
// assumes 48 ref_clk cycles per pixel and a free-running ref_clk
`timescale 1ns/100ps

module ccdet_ccd_model (
    input  wire logic       ref_clk,
    input  wire logic       horiz_clock_1,
    input  wire logic       reset_gate_clock,
    output logic            master_clock_in,
    output logic [9:0]      adc_code
);
    logic [5:0] step_r = 6'h00;

    initial begin
        master_clock_in = 1'b0;
        adc_code = 10'h155;
    end

    // one master clock cycle per pixel, half high
    always @(posedge ref_clk) begin
        step_r <= (step_r == 6'h2F) ? 6'h00 : step_r + 6'h01;
        master_clock_in <= (step_r < 6'h18);
        // code moves every step so a transparent latch is visible
        adc_code <= adc_code + {7'h1D, horiz_clock_1, reset_gate_clock, 1'b1};
    end
endmodule

// ===== tb/tb_top.sv
// testbench of the ccd edge timing and front-end control block
// assumes the design files and the ccd sensor model are compiled first
`timescale 1ns/100ps

module tb_top;
    import ccdet_pkg::*;
    logic ref_clk = 0, resetn = 0, reg_wr_en = 0, reg_rd_en = 0, gain_update = 0;
    logic pixel_blank_pulse_n = 1, master_clock_in, reg_rd_valid, data_out_oe;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rd_data;
    logic [9:0] clamp_level = 10'h2A5, adc_code, data_out;
    logic [5:0] pixel_phase;
    logic horiz_clock_1, horiz_clock_2, horiz_clock_3, horiz_clock_4, reset_gate_clock;
    logic horiz_clock_1_oe, horiz_clock_2_oe, horiz_clock_3_oe, horiz_clock_4_oe;
    logic reset_gate_oe, reference_sample_strobe, level_sample_strobe, quick_clamp_pulse;
    logic black_clamp_on, black_clamp_fast, dc_restore_bypass;
    ccdet_drive_t drive_strength;
    ccdet_pwr_t   power_state;
    ccdet_gain_t  sampler_gain;
    int n_fail = 0, n_checks = 0, cyc = 0;
    logic [12:0] he, rge;
    logic [11:0] sp, op;
    logic [5:0]  dp, oc;
    logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h10};
    logic [15:0] rv [8] = '{16'h004, 16'h04, 16'h1001, 16'h0801, 16'h0, 16'h024, 16'h0, 16'h0};
    logic [15:0] rm [8] = '{16'hFFF, 16'h3F, 16'h1FFF, 16'h1FFF, 16'h7FFF, 16'hFFF, 16'h3F, 16'h0};

    ccdet_top DUT (.ref_clk, .resetn, .master_clock_in, .reg_wr_en, .reg_rd_en, .reg_addr,
        .reg_wdata, .reg_rd_data, .reg_rd_valid, .pixel_phase, .horiz_clock_1, .horiz_clock_2,
        .horiz_clock_3, .horiz_clock_4, .reset_gate_clock, .horiz_clock_1_oe, .horiz_clock_2_oe,
        .horiz_clock_3_oe, .horiz_clock_4_oe, .reset_gate_oe, .drive_strength,
        .reference_sample_strobe, .level_sample_strobe, .pixel_blank_pulse_n, .adc_code,
        .clamp_level, .gain_update, .data_out, .data_out_oe, .power_state, .black_clamp_on,
        .black_clamp_fast, .quick_clamp_pulse, .dc_restore_bypass, .sampler_gain);
    ccdet_ccd_model sensor (.ref_clk, .horiz_clock_1, .reset_gate_clock, .master_clock_in,
        .adc_code);

    always #4 ref_clk = ~ref_clk;

    task automatic tally_and_finish();
        if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // hang guard, far above the roughly 550 cycles the tests need
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        @(negedge ref_clk);
        chk({15'h0, reg_rd_valid}, 16'h1);
        chk(reg_rd_data, e);
    endtask

    // invalid offsets map to 63, a position the phase never reaches
    function automatic logic [5:0] dec(input logic [5:0] e);
        return (e[3:0] < 4'hC) ? 6'(e[5:4] * 12 + e[3:0]) : 6'h3F;
    endfunction

    function automatic logic [9:0] code_of();
        logic [9:0] c;
        c = !pixel_blank_pulse_n ? (op[5] ? clamp_level : 10'h0) : adc_code;
        return oc[5] ? c ^ (c >> 1) : c;
    endfunction

    // program all timing registers, then follow two pixel periods cycle by cycle
    task automatic run(input logic [12:0] h, input logic [12:0] r, input logic [11:0] s,
                       input logic [5:0] d, input logic [5:0] o, input logic [11:0] p,
                       input logic bl);
        logic hm, rgm, a, b;
        logic [5:0] pp;
        logic [9:0] pc, ed;
        {he, rge, sp, dp, oc, op} = {h, r, s, d, o, p};
        wr(8'h60, 16'(h));
        pixel_blank_pulse_n <= bl;
        wr(8'h61, 16'(r));
        wr(8'h63, 16'(s));
        wr(8'h64, 16'(d));
        wr(8'h04, 16'(o));
        wr(8'h00, 16'(p));
        {hm, rgm, pp, pc, ed} = {2'b00, 6'h3E, 20'h0};
        for (int i = 0; i < 96; i++) begin
            @(negedge ref_clk);
            hm = (pp == dec(he[6:1])) ? 1'b1 : (pp == dec(he[12:7])) ? 1'b0 : hm;
            rgm = (pp == dec(rge[6:1])) ? 1'b1 : (pp == dec(rge[12:7])) ? 1'b0 : rgm;
            if (oc[4] || pp == dec(dp)) ed = pc;
            a = hm ~^ he[0];
            b = rgm ~^ rge[0];
            if (i >= 48) begin
                chk(16'(pixel_phase), (pp == 6'h2F) ? 16'h0 : 16'(pp + 6'h01));
                chk({11'h0, horiz_clock_1, horiz_clock_2, horiz_clock_3, horiz_clock_4,
                     reset_gate_clock}, {11'h0, a, ~a, a, ~a, b});
                chk({14'h0, reference_sample_strobe, level_sample_strobe},
                    {14'h0, pp == dec(sp[5:0]), pp == dec(sp[11:6])});
                chk(16'(data_out), 16'(ed));
            end
            pp = pixel_phase;
            pc = code_of();
        end
    endtask

    initial begin
        logic [11:0] o;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], rv[i]);
            wr(ra[i], 16'hFD3F);
            rd(ra[i], 16'hFD3F & rm[i]);
            wr(ra[i], rv[i]);
        end
        pixel_blank_pulse_n <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            o = {2'(i), 1'b0, i[0], 2'b00, i[1], i[0], i[1], i[0], 2'(i)};
            wr(8'h00, 16'(o));
            @(posedge ref_clk);
            gain_update <= 1'b1;
            @(posedge ref_clk);
            gain_update <= 1'b0;
            @(negedge ref_clk);
            chk(16'(power_state), (i == 0) ? 16'h1 : (i == 1) ? 16'h2 : 16'h4);
            chk(16'(sampler_gain), (i == 1) ? 16'h2 : (i == 2) ? 16'h4 : 16'h1);
            chk({12'h0, black_clamp_on, black_clamp_fast, quick_clamp_pulse, dc_restore_bypass},
                {12'h0, i[0], i[1], i[0], i[0]});
        end
        wr(8'h00, 16'h0004);
        pixel_blank_pulse_n <= 1'b1;
        wr(8'h00, 16'h0100);
        @(negedge ref_clk);
        chk(16'(dc_restore_bypass), 16'h0);
        for (int i = 0; i < 2; i++) begin
            wr(8'h62, i ? 16'h0E07 : 16'h70C8);
            wr(8'h04, i ? 16'h0008 : 16'h0000);
            @(negedge ref_clk);
            chk(16'(drive_strength), i ? 16'h0E07 : 16'h70C8);
            chk({10'h0, horiz_clock_1_oe, horiz_clock_2_oe, horiz_clock_3_oe,
                 horiz_clock_4_oe, reset_gate_oe, data_out_oe},
                i ? 16'h24 : 16'h1B);
        end
        run(13'h1001, 13'h0801, 12'h024, 6'h00, 6'h04, 12'h004, 1'b0);
        run({6'h3B, 6'h10, 1'b1}, {6'h05, 6'h2B, 1'b0}, {6'h10, 6'h3B}, 6'h1B, 6'h20,
            12'h004, 1'b1);
        run({6'h10, 6'h0C, 1'b0}, {6'h21, 6'h21, 1'b1}, {6'h00, 6'h2B}, 6'h00, 6'h30,
            12'h004, 1'b1);
        run({6'h3B, 6'h10, 1'b1}, {6'h05, 6'h2B, 1'b0}, {6'h10, 6'h3B}, 6'h3B, 6'h20,
            12'h024, 1'b0);
        tally_and_finish();
    end
endmodule
